// [bench/dac_datapath_config_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) chk(n, 32'(e), 32'(g))
module dac_datapath_config_regs_tb;
	localparam int DLY = 2;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        reg_wr = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [15:0] port_a_bus = 16'h0000;
	logic [15:0] port_b_bus = 16'h0000;
	logic        tx_enable_pin = 1'b0;
	logic        phase_strobe_pin = 1'b0;
	logic        b_sample_flag_pin = 1'b0;
	logic [15:0] chan_a_out, chan_b_out;
	logic        osc_enable, quad_corr_enable, inverse_sinc_enable;
	logic        four_wire_port_select, half_rate_enable;
	logic [7:0]  factory_bypass_mask, chan_a_trim, chan_b_trim;
	logic [31:0] osc_freq_word, osc_phase_acc;
	logic [15:0] osc_phase_word;
	logic        divider_resync, fifo_ptr_reset;
	int          m [0:31];
	int          trim_b;
	logic [15:0] cnt_prev;
	int          bad_count = 0;
	int          checks_done = 0;
	int          cycles = 0;

	dac_datapath_config_regs dac_datapath_config_regs_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.port_a_bus(port_a_bus), .port_b_bus(port_b_bus), .tx_enable_pin(tx_enable_pin),
		.phase_strobe_pin(phase_strobe_pin), .b_sample_flag_pin(b_sample_flag_pin),
		.chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .osc_enable(osc_enable),
		.quad_corr_enable(quad_corr_enable), .inverse_sinc_enable(inverse_sinc_enable),
		.four_wire_port_select(four_wire_port_select), .half_rate_enable(half_rate_enable),
		.factory_bypass_mask(factory_bypass_mask), .osc_freq_word(osc_freq_word),
		.osc_phase_word(osc_phase_word), .osc_phase_acc(osc_phase_acc),
		.chan_a_trim(chan_a_trim), .chan_b_trim(chan_b_trim),
		.divider_resync(divider_resync), .fifo_ptr_reset(fifo_ptr_reset));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#DLY;
		end
	endtask

	task automatic reset_dut();
		rst_n = 1'b0;
		foreach (m[i]) m[i] = 0;
		m[3] = 'h80;
		m[12] = 'h40;
		trim_b = 0;
		repeat (6) @(posedge ref_clk);
		#DLY;
		rst_n = 1'b1;
	endtask

	task automatic wr(input int a, input int d);
		// One edge passes with the strobe low, so back-to-back writes stay distinct
		@(posedge ref_clk);
		#DLY;
		reg_wr = 1'b1;
		reg_addr = 5'(a);
		reg_wdata = 8'(d);
		@(posedge ref_clk);
		#DLY;
		reg_wr = 1'b0;
		if (a >= 3 && a <= 16) m[a] = d & 'hff;
		if (a == 15) trim_b = m[16];
	endtask

	task automatic check_regs();
		for (int a = 0; a < 18; a++) begin
			reg_addr = 5'(a);
			idle(1);
			`CHECK("rdata", m[a], reg_rdata);
		end
		`CHECK("osc_en", m[3][7], osc_enable);
		`CHECK("quad_en", m[3][5], quad_corr_enable);
		`CHECK("isinc_en", m[3][0], inverse_sinc_enable);
		`CHECK("four_wire", m[4][7], four_wire_port_select);
		`CHECK("half_rate", m[4][5], half_rate_enable);
		`CHECK("bypass", m[8], factory_bypass_mask);
		`CHECK("freq", {m[11][7:0], m[12][7:0], m[10][7:0], m[9][7:0]}, osc_freq_word);
		`CHECK("phase", {m[14][7:0], m[13][7:0]}, osc_phase_word);
		`CHECK("trim_a", m[15], chan_a_trim);
		`CHECK("trim_b", trim_b, chan_b_trim);
	endtask

	function automatic logic [15:0] mixv(input int sel, input int st, input logic [15:0] a,
			input logic [15:0] b, input bit chb);
		logic [15:0] v;
		bit          ng;
		v = (chb ^ (sel >= 8 && st % 2 == 1)) ? b : a;
		case (sel >> 2)
			0: ng = 0;
			1: ng = (st % 2 == 1) ^ !(chb ? sel[0] : sel[1]);
			2: ng = (chb ? st >= 2 : (st == 1 || st == 2)) ^ (chb ? sel[0] : sel[1]);
			default: ng = (chb ? (st == 1 || st == 2) : st >= 2) ^ (chb ? sel[0] : sel[1]);
		endcase
		return ng ? -v : v;
	endfunction

	task automatic mix_run(input int sel);
		int          n;
		logic [15:0] a, b, va, vb;
		logic [31:0] acc, fw;
		n = 0;
		fw = {m[11][7:0], m[12][7:0], m[10][7:0], m[9][7:0]};
		phase_strobe_pin = 1'b1;
		while (divider_resync !== 1'b1 && n < 8) begin
			idle(1);
			n++;
		end
		`CHECK("div_resync", 1, divider_resync);
		phase_strobe_pin = 1'b0;
		idle(1);
		`CHECK("acc_clear", 0, osc_phase_acc);
		acc = 0;
		for (int st = 0; st < 8; st++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			port_a_bus = a;
			port_b_bus = b;
			idle(1);
			if (m[3][7] && m[3][6]) begin
				a = a << 1;
				b = b << 1;
			end
			if (m[3][7]) acc = acc + fw;
			va = mixv(sel, st % 4, a, b, 1'b0);
			vb = mixv(sel, st % 4, a, b, 1'b1);
			if (m[4][3]) vb = -vb;
			`CHECK("chan_a", va, chan_a_out);
			`CHECK("chan_b", vb, chan_b_out);
			`CHECK("acc", acc, osc_phase_acc);
		end
	endtask

	task automatic set_src(input int code, input logic v);
		case (code)
			0: tx_enable_pin = v;
			1: phase_strobe_pin = v;
			2: b_sample_flag_pin = v;
			3: port_b_bus[15] = v;
			default: port_a_bus[15] = v;
		endcase
	endtask

	task automatic count_sync(input int n, input int exp_cnt);
		int c;
		c = 0;
		repeat (n) begin
			if (fifo_ptr_reset === 1'b1) c++;
			idle(1);
		end
		`CHECK("sync_pulses", exp_cnt, c);
	endtask

	initial begin
		void'($urandom(32'h499eb424));
		reset_dut();
		check_regs();
		$display("test reset_values done");
		for (int a = 3; a < 18; a++) begin
			wr(a, (a == 5) ? 'h18 : (a == 8) ? 0 : $urandom);
		end
		check_regs();
		wr(15, $urandom);
		wr(8, 0);
		check_regs();
		clk_en = 1'b0;
		reg_wr = 1'b1;
		reg_addr = 5'h06;
		reg_wdata = 8'(~m[6]);
		idle(1);
		reg_wr = 1'b0;
		clk_en = 1'b1;
		check_regs();
		$display("test register_access done");
		wr(5, 'hf8);
		for (int s = 0; s < 16; s++) begin
			wr(3, (s << 1) | ($urandom & 'he1));
			wr(4, ($urandom & 1) << 3);
			mix_run(s);
		end
		$display("test coarse_mixer done");
		wr(3, 0);
		wr(6, $urandom);
		wr(7, $urandom);
		wr(4, 'h40);
		port_a_bus = 16'($urandom);
		port_b_bus = 16'($urandom);
		idle(1);
		`CHECK("fixed_a", {m[7][7:0], m[6][7:0]}, chan_a_out);
		`CHECK("fixed_b", {m[7][7:0], m[6][7:0]}, chan_b_out);
		wr(4, 3);
		idle(1);
		`CHECK("cnt_off", port_a_bus, chan_a_out);
		for (int c = 4; c < 8; c++) begin
			wr(4, c);
			idle(1);
			`CHECK("cnt_mask", 0, chan_a_out & ~((c == 5) ? 16'h007f : (c == 6) ? 16'h07c0 :
				(c == 7) ? 16'hf800 : 16'hffff));
			`CHECK("cnt_both", chan_a_out, chan_b_out);
			if (c == 4) begin
				cnt_prev = chan_a_out;
				idle(1);
				`CHECK("cnt_step", 16'(cnt_prev + 16'h0001), chan_a_out);
			end
		end
		wr(4, 'h20);
		port_a_bus = 16'($urandom);
		port_b_bus = 16'($urandom);
		idle(1);
		`CHECK("half_a0", port_a_bus, chan_a_out);
		`CHECK("half_b0", port_b_bus, chan_b_out);
		idle(1);
		`CHECK("half_a1", port_b_bus, chan_a_out);
		$display("test data_sources done");
		wr(4, 0);
		port_a_bus = 16'h0000;
		port_b_bus = 16'h0000;
		for (int c = 0; c < 5; c++) begin
			wr(5, c << 2);
			idle(6);
			set_src(c, 1'b1);
			count_sync(10, 1);
			set_src(c, 1'b0);
			idle(6);
			if (c == 4) begin
				set_src(c, 1'b1);
				count_sync(10, 0);
				set_src(c, 1'b0);
			end
		end
		wr(5, 'h14);
		idle(6);
		wr(6, 'h5a);
		count_sync(6, 1);
		wr(5, 'h18);
		tx_enable_pin = 1'b1;
		phase_strobe_pin = 1'b1;
		count_sync(10, 0);
		tx_enable_pin = 1'b0;
		phase_strobe_pin = 1'b0;
		wr(5, 'h1c);
		count_sync(6, 6);
		$display("test fifo_sync done");
		reset_dut();
		check_regs();
		$display("test second_reset done");
		tally_and_finish();
	end
endmodule // dac_datapath_config_regs_tb
`default_nettype wire

// [hdl/dac_cfg_pkg.sv]
package dac_cfg_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 16;
	localparam int PIN_CNT = 5;
	localparam logic [4:0] ADDR_CONFIG_B = 5'h03;
	localparam logic [4:0] ADDR_CONFIG_C = 5'h04;
	localparam logic [4:0] ADDR_SYNC = 5'h05;
	localparam logic [4:0] ADDR_FIXED_LO = 5'h06;
	localparam logic [4:0] ADDR_FIXED_HI = 5'h07;
	localparam logic [4:0] ADDR_BYPASS = 5'h08;
	localparam logic [4:0] ADDR_STEP0 = 5'h09;
	localparam logic [4:0] ADDR_STEP1 = 5'h0a;
	localparam logic [4:0] ADDR_STEP3 = 5'h0b;
	localparam logic [4:0] ADDR_STEP2 = 5'h0c;
	localparam logic [4:0] ADDR_PHASE0 = 5'h0d;
	localparam logic [4:0] ADDR_PHASE1 = 5'h0e;
	localparam logic [4:0] ADDR_TRIM_A = 5'h0f;
	localparam logic [4:0] ADDR_TRIM_B = 5'h10;
	localparam logic [7:0] RST_CONFIG_B = 8'h80;
	localparam logic [7:0] RST_STEP2 = 8'h40;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Datapath config B fields
	localparam int OSC_EN_BIT = 7;
	localparam int OSC_GAIN_BIT = 6;
	localparam int QUAD_BIT = 5;
	localparam int MIX_HI = 4;
	localparam int MIX_LO = 1;
	localparam int ISINC_BIT = 0;
	// Datapath config C fields
	localparam int FOUR_WIRE_BIT = 7;
	localparam int FIXED_BIT = 6;
	localparam int HALF_BIT = 5;
	localparam int USB_BIT = 3;
	localparam int CNT_HI = 2;
	localparam int CNT_LO = 0;
	// Sync control fields
	localparam int DIV_SYNC_BIT = 7;
	localparam int ACC_SYNC_BIT = 6;
	localparam int MIX_SYNC_BIT = 5;
	localparam int FSYNC_HI = 4;
	localparam int FSYNC_LO = 2;
	// Coarse mixer families (upper two select bits)
	localparam logic [1:0] MIX_NONE = 2'h0;
	localparam logic [1:0] MIX_HALF = 2'h1;
	localparam logic [1:0] MIX_QUARTER = 2'h2;
	localparam logic [1:0] MIX_NEG_QUARTER = 2'h3;
	// Counter source codes
	localparam logic [2:0] CNT_ALL = 3'h4;
	localparam logic [2:0] CNT_LSB = 3'h5;
	localparam logic [2:0] CNT_MID = 3'h6;
	localparam logic [2:0] CNT_MSB = 3'h7;
	localparam int CNT_LSB_W = 7;
	localparam int CNT_FIELD_W = 5;
	localparam int CNT_MID_POS = 6;
	localparam int CNT_MSB_POS = 11;
	// Sync pin indices and FIFO sync codes
	localparam int PIN_TXEN = 0;
	localparam int PIN_STROBE = 1;
	localparam int PIN_BFLAG = 2;
	localparam int PIN_B15 = 3;
	localparam int PIN_A15 = 4;
	localparam logic [2:0] FS_A15_ONCE = 3'h4;
	localparam logic [2:0] FS_SOFT = 3'h5;
	localparam logic [2:0] FS_OFF = 3'h6;
	localparam logic [2:0] FS_ON = 3'h7;
	localparam int MSB_BIT = 15;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} sample_pair_t;
endpackage

// [hdl/dac_datapath_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Config B bit 7 enables oscillator mixer; register resets to 0x80.
// R2 - Oscillator gain bit doubles oscillator mixer output, else unity gain.
// R3 - Quadrature gain/phase correction applied only while its enable bit is set.
// R4 - Four-bit coarse mix select; upper bits 00 pass A and B unchanged.
// R5 - Codes 01xx alternate signs each sample; bit1 starts A plus, bit0 B.
// R6 - Codes 10xx give A +A,-B,-A,+B and B +B,+A,-B,-A; bits negate.
// R7 - Codes 11xx give A +A,+B,-A,-B and B +B,-A,-B,+A; bits negate.
// R8 - Inverse-sinc filter inserted when its bit is set, bypassed when clear.
// R9 - Four-wire select bit picks four-wire port, else three-wire shared data.
// R10 - Fixed-sample bit replaces both channels with word from 0x07:0x06.
// R11 - Half-rate mode carries channel A samples over both input buses.
// R12 - Sideband bit inverts channel B data for upper sideband output.
// R13 - Counter source field: 0xx off, 100 all, 101 7 LSBs, 110 mids, 111 MSBs.
// R14 - Divider resync bit: strobe rising edge initialises clock dividers.
// R15 - Accumulator resync bit: strobe rising edge clears oscillator phase accumulator.
// R16 - Coarse mixer resync bit: strobe rising edge restarts the sign sequence.
// R17 - Rising edge of selected sync source resets both FIFO pointers.
// R18 - Code 100 uses only first port A bit 15 transition, then ignores.
// R19 - Code 101 software write sync, 110 never, 111 always active.
// R20 - Frequency word bytes at 0x09,0x0a,0x0c,0x0b; byte at 0x0c resets 0x40.
// R21 - Phase offset word low byte at 0x0d, high byte at 0x0e.
// R22 - Channel B trim low byte write waits until channel A trim write.
// R23 - Software leaves the factory bypass mask register at zero.
// R24 - Coarse mixer steps once per sample, wraps after four, restarts at step zero.
module dac_datapath_config_regs (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        reg_wr,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] port_a_bus,
	input  wire logic [15:0] port_b_bus,
	input  wire logic        tx_enable_pin,
	input  wire logic        phase_strobe_pin,
	input  wire logic        b_sample_flag_pin,
	output logic      [15:0] chan_a_out,
	output logic      [15:0] chan_b_out,
	output logic             osc_enable,
	output logic             quad_corr_enable,
	output logic             inverse_sinc_enable,
	output logic             four_wire_port_select,
	output logic             half_rate_enable,
	output logic      [7:0]  factory_bypass_mask,
	output logic      [31:0] osc_freq_word,
	output logic      [15:0] osc_phase_word,
	output logic      [31:0] osc_phase_acc,
	output logic      [7:0]  chan_a_trim,
	output logic      [7:0]  chan_b_trim,
	output logic             divider_resync,
	output logic             fifo_ptr_reset
);
	localparam logic [4:0] FIRST = dac_cfg_pkg::ADDR_CONFIG_B;
	localparam logic [4:0] LAST = dac_cfg_pkg::ADDR_TRIM_B;

	logic [7:0]             regs_reg [FIRST:LAST];
	logic [7:0]             trim_b_reg;
	logic [1:0]             step_reg;
	logic [15:0]            count_reg;
	logic                   half_phase_reg;
	logic                   one_shot_armed_reg;
	logic                   soft_sync_reg;
	logic [31:0]            acc_reg;
	logic [dac_cfg_pkg::PIN_CNT-1:0] pins;
	logic [dac_cfg_pkg::PIN_CNT-1:0] sync1_reg;
	logic [dac_cfg_pkg::PIN_CNT-1:0] sync2_reg;
	logic [dac_cfg_pkg::PIN_CNT-1:0] sync3_reg;
	logic [dac_cfg_pkg::PIN_CNT-1:0] level_reg;
	logic [dac_cfg_pkg::PIN_CNT-1:0] rise;
	logic [7:0]             cfg_b;
	logic [7:0]             cfg_c;
	logic [7:0]             sync_ctl;
	logic [3:0]             mix_sel;
	logic [2:0]             cnt_sel;
	logic [2:0]             fsync_sel;
	logic                   strobe_rise;
	logic                   mix_restart;
	logic                   fsync_fire;
	dac_cfg_pkg::sample_pair_t src;
	dac_cfg_pkg::sample_pair_t gained;
	dac_cfg_pkg::sample_pair_t mixed;

	function automatic logic [7:0] reset_value(input logic [4:0] a);
		if (a == dac_cfg_pkg::ADDR_CONFIG_B) begin
			return dac_cfg_pkg::RST_CONFIG_B; // R1
		end
		if (a == dac_cfg_pkg::ADDR_STEP2) begin
			return dac_cfg_pkg::RST_STEP2; // R20
		end
		return dac_cfg_pkg::RST_ZERO;
	endfunction

	function automatic logic wr_hit(input logic [4:0] a);
		return clk_en && reg_wr && (reg_addr == a);
	endfunction

	function automatic dac_cfg_pkg::sample_pair_t coarse_mix(
		input logic [3:0]  sel,
		input logic [1:0]  step,
		input dac_cfg_pkg::sample_pair_t s
	);
		dac_cfg_pkg::sample_pair_t r;
		r = s;
		case (sel[3:2])
			dac_cfg_pkg::MIX_NONE: begin
				r = s; // R4
			end
			dac_cfg_pkg::MIX_HALF: begin
				r.a = (sel[1] ^ step[0]) ? s.a : -s.a; // R5
				r.b = (sel[0] ^ step[0]) ? s.b : -s.b; // R5
			end
			dac_cfg_pkg::MIX_QUARTER: begin
				case (step) // R6
					2'h0: begin
						r.a = s.a;
						r.b = s.b;
					end
					2'h1: begin
						r.a = -s.b;
						r.b = s.a;
					end
					2'h2: begin
						r.a = -s.a;
						r.b = -s.b;
					end
					default: begin
						r.a = s.b;
						r.b = -s.a;
					end
				endcase
				if (sel[1]) begin
					r.a = -r.a; // R6
				end
				if (sel[0]) begin
					r.b = -r.b; // R6
				end
			end
			default: begin
				case (step) // R7
					2'h0: begin
						r.a = s.a;
						r.b = s.b;
					end
					2'h1: begin
						r.a = s.b;
						r.b = -s.a;
					end
					2'h2: begin
						r.a = -s.a;
						r.b = -s.b;
					end
					default: begin
						r.a = -s.b;
						r.b = s.a;
					end
				endcase
				if (sel[1]) begin
					r.a = -r.a; // R7
				end
				if (sel[0]) begin
					r.b = -r.b; // R7
				end
			end
		endcase
		return r;
	endfunction

	// Register file; channel B trim entry holds the pending value
	generate
		for (genvar i = FIRST; i <= LAST; i++) begin : g_reg
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					regs_reg[i] <= reset_value(5'(i));
				end else if (wr_hit(5'(i))) begin
					regs_reg[i] <= reg_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= dac_cfg_pkg::RST_ZERO;
		end else if (clk_en) begin
			if (reg_addr >= FIRST && reg_addr <= LAST) begin
				reg_rdata <= regs_reg[reg_addr];
			end else begin
				reg_rdata <= dac_cfg_pkg::RST_ZERO;
			end
		end
	end

	assign cfg_b = regs_reg[dac_cfg_pkg::ADDR_CONFIG_B];
	assign cfg_c = regs_reg[dac_cfg_pkg::ADDR_CONFIG_C];
	assign sync_ctl = regs_reg[dac_cfg_pkg::ADDR_SYNC];
	assign mix_sel = cfg_b[dac_cfg_pkg::MIX_HI:dac_cfg_pkg::MIX_LO];
	assign cnt_sel = cfg_c[dac_cfg_pkg::CNT_HI:dac_cfg_pkg::CNT_LO];
	assign fsync_sel = sync_ctl[dac_cfg_pkg::FSYNC_HI:dac_cfg_pkg::FSYNC_LO];

	assign osc_enable = cfg_b[dac_cfg_pkg::OSC_EN_BIT]; // R1
	assign quad_corr_enable = cfg_b[dac_cfg_pkg::QUAD_BIT]; // R3
	assign inverse_sinc_enable = cfg_b[dac_cfg_pkg::ISINC_BIT]; // R8
	assign four_wire_port_select = cfg_c[dac_cfg_pkg::FOUR_WIRE_BIT]; // R9
	assign half_rate_enable = cfg_c[dac_cfg_pkg::HALF_BIT]; // R11
	assign factory_bypass_mask = regs_reg[dac_cfg_pkg::ADDR_BYPASS]; // R23
	assign osc_freq_word = {regs_reg[dac_cfg_pkg::ADDR_STEP3],
		regs_reg[dac_cfg_pkg::ADDR_STEP2],
		regs_reg[dac_cfg_pkg::ADDR_STEP1],
		regs_reg[dac_cfg_pkg::ADDR_STEP0]}; // R20
	assign osc_phase_word = {regs_reg[dac_cfg_pkg::ADDR_PHASE1],
		regs_reg[dac_cfg_pkg::ADDR_PHASE0]}; // R21
	assign chan_a_trim = regs_reg[dac_cfg_pkg::ADDR_TRIM_A];
	assign chan_b_trim = trim_b_reg;
	assign osc_phase_acc = acc_reg;

	// Channel B trim takes the pending byte only when channel A trim is written
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_b_reg <= dac_cfg_pkg::RST_ZERO;
		end else if (wr_hit(dac_cfg_pkg::ADDR_TRIM_A)) begin
			trim_b_reg <= regs_reg[dac_cfg_pkg::ADDR_TRIM_B]; // R22
		end
	end

	// Pin synchronisers; a level counts once stages two and three agree
	assign pins = {port_a_bus[dac_cfg_pkg::MSB_BIT], port_b_bus[dac_cfg_pkg::MSB_BIT],
		b_sample_flag_pin, phase_strobe_pin, tx_enable_pin};
	generate
		for (genvar p = 0; p < dac_cfg_pkg::PIN_CNT; p++) begin : g_pin
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_reg[p] <= 1'b0;
					sync2_reg[p] <= 1'b0;
					sync3_reg[p] <= 1'b0;
					level_reg[p] <= 1'b0;
				end else if (clk_en) begin
					sync1_reg[p] <= pins[p];
					sync2_reg[p] <= sync1_reg[p];
					sync3_reg[p] <= sync2_reg[p];
					if (sync2_reg[p] == sync3_reg[p]) begin
						level_reg[p] <= sync3_reg[p];
					end
				end
			end
			assign rise[p] = sync2_reg[p] && sync3_reg[p] && !level_reg[p];
		end
	endgenerate

	assign strobe_rise = clk_en && rise[dac_cfg_pkg::PIN_STROBE];
	assign mix_restart = strobe_rise && sync_ctl[dac_cfg_pkg::MIX_SYNC_BIT]; // R16
	assign divider_resync = strobe_rise && sync_ctl[dac_cfg_pkg::DIV_SYNC_BIT]; // R14

	// FIFO sync source selection
	always_comb begin
		fsync_fire = 1'b0;
		case (fsync_sel)
			3'h0: fsync_fire = rise[dac_cfg_pkg::PIN_TXEN]; // R17
			3'h1: fsync_fire = rise[dac_cfg_pkg::PIN_STROBE]; // R17
			3'h2: fsync_fire = rise[dac_cfg_pkg::PIN_BFLAG]; // R17
			3'h3: fsync_fire = rise[dac_cfg_pkg::PIN_B15]; // R17
			dac_cfg_pkg::FS_A15_ONCE: fsync_fire = rise[dac_cfg_pkg::PIN_A15] &&
				one_shot_armed_reg; // R18
			dac_cfg_pkg::FS_SOFT: fsync_fire = soft_sync_reg; // R19
			dac_cfg_pkg::FS_OFF: fsync_fire = 1'b0; // R19
			default: fsync_fire = 1'b1; // R19
		endcase
	end
	assign fifo_ptr_reset = fsync_fire && (clk_en || fsync_sel == dac_cfg_pkg::FS_ON);

	// One-shot rearms on any sync control write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			one_shot_armed_reg <= 1'b1;
		end else if (wr_hit(dac_cfg_pkg::ADDR_SYNC)) begin
			one_shot_armed_reg <= 1'b1;
		end else if (clk_en && fsync_sel == dac_cfg_pkg::FS_A15_ONCE &&
			rise[dac_cfg_pkg::PIN_A15]) begin
			one_shot_armed_reg <= 1'b0; // R18
		end
	end

	// Software sync pulses one cycle after any write while code 101 is selected
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_sync_reg <= 1'b0;
		end else if (clk_en) begin
			soft_sync_reg <= reg_wr && fsync_sel == dac_cfg_pkg::FS_SOFT; // R19
		end
	end

	// Oscillator phase accumulator
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
		end else if (clk_en) begin
			if (strobe_rise && sync_ctl[dac_cfg_pkg::ACC_SYNC_BIT]) begin
				acc_reg <= '0; // R15
			end else if (osc_enable) begin
				acc_reg <= acc_reg + osc_freq_word;
			end
		end
	end

	// Coarse mixer step, counter source and half-rate phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= 2'h0;
		end else if (clk_en) begin
			if (mix_restart) begin
				step_reg <= 2'h0; // R24
			end else begin
				step_reg <= step_reg + 2'h1; // R24
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
			half_phase_reg <= 1'b0;
		end else if (clk_en) begin
			count_reg <= count_reg + 16'h0001;
			half_phase_reg <= half_rate_enable && !half_phase_reg;
		end
	end

	// Source select: counter, fixed word, or input buses
	always_comb begin
		src.a = half_rate_enable && half_phase_reg ? port_b_bus : port_a_bus; // R11
		src.b = port_b_bus;
		if (cfg_c[dac_cfg_pkg::FIXED_BIT]) begin
			src.a = {regs_reg[dac_cfg_pkg::ADDR_FIXED_HI],
				regs_reg[dac_cfg_pkg::ADDR_FIXED_LO]}; // R10
			src.b = src.a; // R10
		end
		case (cnt_sel)
			dac_cfg_pkg::CNT_ALL: src.a = count_reg; // R13
			dac_cfg_pkg::CNT_LSB: src.a = {9'h000,
				count_reg[dac_cfg_pkg::CNT_LSB_W-1:0]}; // R13
			dac_cfg_pkg::CNT_MID: src.a = {5'h00,
				count_reg[dac_cfg_pkg::CNT_FIELD_W-1:0], 6'h00}; // R13
			dac_cfg_pkg::CNT_MSB: src.a = {count_reg[dac_cfg_pkg::CNT_FIELD_W-1:0],
				11'h000}; // R13
			default: src.a = src.a;
		endcase
		if (cnt_sel[2]) begin
			src.b = src.a; // R13
		end
	end

	always_comb begin
		gained = src;
		if (osc_enable && cfg_b[dac_cfg_pkg::OSC_GAIN_BIT]) begin
			gained.a = {src.a[14:0], 1'b0}; // R2
			gained.b = {src.b[14:0], 1'b0}; // R2
		end
		mixed = coarse_mix(mix_sel, step_reg, gained);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_a_out <= '0;
			chan_b_out <= '0;
		end else if (clk_en) begin
			chan_a_out <= mixed.a;
			chan_b_out <= cfg_c[dac_cfg_pkg::USB_BIT] ? -mixed.b : mixed.b; // R12
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence strobe_resync_s;
		strobe_rise && sync_ctl[dac_cfg_pkg::MIX_SYNC_BIT];
	endsequence

	sequence write_a_trim_s;
		wr_hit(dac_cfg_pkg::ADDR_TRIM_A);
	endsequence

	chk_mix_restart_zero: assert property (strobe_resync_s |=> step_reg == 2'h0) // R16
		else $error("coarse mixer not restarted");
	chk_mix_step_wrap: assert property (clk_en && !mix_restart |=>
		step_reg == $past(step_reg) + 2'h1) // R24
		else $error("coarse mixer step did not advance");
	chk_trim_b_hold: assert property (wr_hit(dac_cfg_pkg::ADDR_TRIM_B) |=>
		$stable(chan_b_trim)) // R22
		else $error("channel B trim applied early");
	chk_trim_b_apply: assert property (write_a_trim_s |=>
		chan_b_trim == $past(regs_reg[dac_cfg_pkg::ADDR_TRIM_B])) // R22
		else $error("channel B trim not applied");
	chk_acc_clear_strobe: assert property (strobe_rise &&
		sync_ctl[dac_cfg_pkg::ACC_SYNC_BIT] |=> osc_phase_acc == 32'h0) // R15
		else $error("accumulator not cleared");
	chk_fifo_always_on: assert property (fsync_sel == dac_cfg_pkg::FS_ON |-> fifo_ptr_reset) // R19
		else $error("sync not held active");
	chk_fifo_one_shot: assert property (fsync_sel == dac_cfg_pkg::FS_A15_ONCE &&
		!one_shot_armed_reg |-> !fifo_ptr_reset) // R18
		else $error("one-shot sync fired twice");
	chk_fifo_disabled: assert property (fsync_sel == dac_cfg_pkg::FS_OFF |-> !fifo_ptr_reset) // R19
		else $error("disabled sync fired");
	chk_fixed_word_out: assert property (clk_en && cfg_c[dac_cfg_pkg::FIXED_BIT] &&
		!cnt_sel[2] && mix_sel[3:2] == dac_cfg_pkg::MIX_NONE &&
		!cfg_b[dac_cfg_pkg::OSC_GAIN_BIT] |=> chan_a_out ==
		$past({regs_reg[dac_cfg_pkg::ADDR_FIXED_HI], regs_reg[dac_cfg_pkg::ADDR_FIXED_LO]})) // R10
		else $error("fixed word not output");
	chk_divider_resync: assert property (divider_resync |->
		sync_ctl[dac_cfg_pkg::DIV_SYNC_BIT] && rise[dac_cfg_pkg::PIN_STROBE]) // R14
		else $error("divider resync without strobe");
endmodule // dac_datapath_config_regs
`default_nettype wire
